// File: rtl/cache_decide.sv
/*
  Combinational cacheability decision for one capture write.
  Assumes pointers count 16-line groups and the head is measured from full frame start.
*/
`timescale 1ns/100ps

`include "capture_write_regs.svh"

module cache_decide
  import capture_write_pkg::*;
(
  input  wire logic                i_enable,
  input  wire ptr_type             i_max_diff,
  input  wire ptr_type             i_tail,
  input  wire ptr_type             i_head,
  input  wire ptr_type             i_vactive,
  input  wire logic                i_same_frame,
  output logic                     o_cacheable
);

  logic [`PTR_W:0] diff_ext;

  // Distance in pointer units; one extra bit keeps the wrap sum from overflowing
  always_comb
  begin
    diff_ext = '0;
    o_cacheable = 1'b0;
    if (i_same_frame)
    begin
      if (i_head < i_tail)
      begin
        diff_ext = {1'b0, i_tail} - {1'b0, i_head};
        o_cacheable = (diff_ext <= {1'b0, i_max_diff}); // [R3]
      end
      else
      begin
        o_cacheable = 1'b1; // [R4]
      end
    end
    else if (i_head > i_vactive)
    begin
      o_cacheable = (i_tail <= i_max_diff); // [R5]
    end
    else
    begin
      diff_ext = {1'b0, i_vactive} - {1'b0, i_head} + {1'b0, i_tail};
      o_cacheable = (diff_ext <= {1'b0, i_max_diff}); // [R6]
    end
    // Disabled caching forces every write uncached
    if (!i_enable)
    begin
      o_cacheable = 1'b0; // [R1] [R17]
    end
  end

endmodule

// File: rtl/capture_write_pkg.sv
/*
  Types shared by the capture writer modules.
  Assumes the constants header is available on the include path.
*/
`include "capture_write_regs.svh"

package capture_write_pkg;
  typedef logic [`PTR_W-1:0] ptr_type;

  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_WRITE = 2'b01,
    ST_DONE  = 2'b10
  } wr_state_type;
endpackage

// File: rtl/capture_write_regs.svh
/*
  Constants for the capture writer: field widths, reset values and pointer granularity.
  Assumes inclusion by bare name from the package and design modules.
*/
`ifndef CAPTURE_WRITE_REGS_SVH
`define CAPTURE_WRITE_REGS_SVH

`define PTR_W          8
`define LINE_W         12
`define PIX_W          13
`define ADDR_W         32
`define DATA_W         32
`define FRAME_W        8
`define LINES_PER_PTR  16
`define PTR_SHIFT      4
`define MAXDIFF_RST    8'h00
`define OFFSET_RST     8'h00
`define BYTES_PER_PIX  32'h0000_0004

`endif

// File: rtl/capture_writer.sv
/*
  Capture writer: takes pipe pixels of the active area, issues memory writes with a
  per-write cache attribute, and reports a frame-relative tail pointer.
  Assumes pixels arrive in raster order of the active area only, one per valid cycle,
  and that the memory side accepts a write whenever it raises ready.
*/
// Notes on behaviour
// R1 - Writes are cacheable only while write caching is enabled, judged against the maximum difference.
// R2 - The cache decision depends on the distance between the writer tail and encoder head.
// R3 - Same frame with head below tail: cacheable when tail minus head is within the maximum difference.
// R4 - Same frame with head not below tail: the encoder is passing, so writes are always cacheable.
// R5 - Different frames with head past the frame height: cacheable when the tail alone is within the limit.
// R6 - Different frames with encoder on the previous frame: cacheable when vactive minus head plus tail is within the limit.
// R7 - Software makes the first capture a full frame; only later captures may be partial.
// R8 - A partial region starts and sizes on 16-line boundaries to match pointer granularity.
// R9 - The reported tail pointer carries a programmable offset for the region position.
// R10 - The encoder head pointer is always relative to full frame start.
// R11 - Software programs the tail offset as lines from frame start in 16-line steps.
// R12 - Software moves the surface base to the first region line for a partial update.
// R13 - Software shrinks pipe and transcoder vertical sizes to the region height.
// R14 - Software aligns plane size, position and panning with the region.
// R15 - The encoder may process all or part of the buffer after a partial capture.
// R16 - Only the active pixel area is written, to the surface given by base and pitch.
// R17 - Each write carries its own cache attribute, and all writes are uncached while disabled.
`timescale 1ns/100ps

`include "capture_write_regs.svh"

module capture_writer
  import capture_write_pkg::*;
(
  input  wire logic                I_CORE_CLK,
  input  wire logic                I_RST,
  input  wire logic                i_capture_start,
  input  wire logic [`FRAME_W-1:0] i_frame_number,
  input  wire logic                i_cache_enable,
  input  wire ptr_type             i_cache_max_diff,
  input  wire ptr_type             i_tail_offset,
  input  wire logic [`ADDR_W-1:0]  i_surface_base,
  input  wire logic [`ADDR_W-1:0]  i_surface_pitch,
  input  wire logic [`PIX_W-1:0]   i_hactive,
  input  wire logic [`LINE_W-1:0]  i_vactive,
  input  wire logic                i_frame_vactive_set,
  input  wire logic [`LINE_W-1:0]  i_frame_vactive,
  input  wire logic                i_pix_valid,
  input  wire logic [`DATA_W-1:0]  i_pix_data,
  output logic                     o_pix_ready,
  input  wire ptr_type             i_head_ptr,
  input  wire logic [`FRAME_W-1:0] i_head_frame,
  output logic                     o_wr_valid,
  input  wire logic                i_wr_ready,
  output logic [`ADDR_W-1:0]       o_wr_addr,
  output logic [`DATA_W-1:0]       o_wr_data,
  output logic                     o_wr_cacheable,
  output ptr_type                  o_tail_ptr,
  output logic [`FRAME_W-1:0]      o_tail_frame,
  output logic                     o_busy,
  output logic                     o_frame_done
);

  wr_state_type            state_q, state_d;
  logic [`PIX_W-1:0]       x_q, x_d;
  logic [`LINE_W-1:0]      y_q, y_d;
  logic [`ADDR_W-1:0]      line_addr_q, line_addr_d;
  logic [`ADDR_W-1:0]      addr_q, addr_d;
  logic [`DATA_W-1:0]      data_q, data_d;
  logic                    valid_q, valid_d;
  logic                    cache_q, cache_d;
  ptr_type                 tail_q, tail_d;
  logic [`FRAME_W-1:0]     frame_q, frame_d;
  logic [`LINE_W-1:0]      height_q, height_d;
  logic                    done_q, done_d;
  logic                    cacheable;
  logic                    take;
  logic                    last_pix;
  ptr_type                 frame_ptr;

  // Line count to pointer units; partial final groups count as a whole group
  function automatic ptr_type lines_to_ptr(input logic [`LINE_W-1:0] lines);
    logic [`LINE_W-1:0] rounded;
    rounded = lines + `LINE_W'(`LINES_PER_PTR - 1);
    return ptr_type'(rounded >> `PTR_SHIFT);
  endfunction

  // Full frame height, used to judge whether the encoder finished its frame
  assign frame_ptr = lines_to_ptr(height_q);

  // Head stays frame relative; only the tail carries the region offset
  cache_decide u_cache_decide
  (
    .i_enable     (i_cache_enable),
    .i_max_diff   (i_cache_max_diff),
    .i_tail       (tail_q),                         // [R2] [R9]
    .i_head       (i_head_ptr),                     // [R10]
    .i_vactive    (frame_ptr),
    .i_same_frame (i_head_frame == frame_q),
    .o_cacheable  (cacheable)
  );

  // Pixel accepted when a write slot is free or draining this cycle
  assign o_pix_ready = (state_q == ST_WRITE) && (!valid_q || i_wr_ready);
  assign take = o_pix_ready && i_pix_valid;
  assign last_pix = (x_q == i_hactive - `PIX_W'(1)) && (y_q == i_vactive - `LINE_W'(1));

  // Next state for the write sequencer and address walk
  always_comb
  begin
    state_d = state_q;
    x_d = x_q;
    y_d = y_q;
    line_addr_d = line_addr_q;
    addr_d = addr_q;
    data_d = data_q;
    valid_d = valid_q && !i_wr_ready;
    cache_d = cache_q;
    tail_d = tail_q;
    frame_d = frame_q;
    height_d = height_q;
    done_d = 1'b0;
    if (i_frame_vactive_set)
    begin
      height_d = i_frame_vactive;
    end
    case (state_q)
      ST_IDLE:
      begin
        if (i_capture_start)
        begin
          state_d = ST_WRITE;
          x_d = '0;
          y_d = '0;
          line_addr_d = i_surface_base;                 // [R16]
          addr_d = i_surface_base;
          tail_d = i_tail_offset;                       // [R9]
          frame_d = i_frame_number;
        end
      end
      ST_WRITE:
      begin
        if (take)
        begin
          valid_d = 1'b1;
          data_d = i_pix_data;
          addr_d = line_addr_q + (`ADDR_W'(x_q) * `BYTES_PER_PIX); // [R16]
          cache_d = cacheable;                          // [R17]
          if (x_q == i_hactive - `PIX_W'(1))
          begin
            x_d = '0;
            y_d = y_q + `LINE_W'(1);
            line_addr_d = line_addr_q + i_surface_pitch; // [R16]
            // Tail advances once per completed 16-line group and once more for a final partial group at the last pixel
            if (y_q[`PTR_SHIFT-1:0] == `PTR_SHIFT'(`LINES_PER_PTR - 1) || last_pix)
            begin
              tail_d = tail_q + ptr_type'(1);            // [R9]
            end
          end
          else
          begin
            x_d = x_q + `PIX_W'(1);
          end
          if (last_pix)
          begin
            state_d = ST_DONE;
          end
        end
      end
      ST_DONE:
      begin
        // Wait for the last write to drain before reporting completion
        if (!valid_q || i_wr_ready)
        begin
          state_d = ST_IDLE;
          done_d = 1'b1;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Registers of the sequencer
  always_ff @(posedge I_CORE_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      state_q <= ST_IDLE;
      x_q <= '0;
      y_q <= '0;
      line_addr_q <= '0;
      addr_q <= '0;
      data_q <= '0;
      valid_q <= 1'b0;
      cache_q <= 1'b0;
      tail_q <= `OFFSET_RST;
      frame_q <= '0;
      height_q <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      x_q <= x_d;
      y_q <= y_d;
      line_addr_q <= line_addr_d;
      addr_q <= addr_d;
      data_q <= data_d;
      valid_q <= valid_d;
      cache_q <= cache_d;
      tail_q <= tail_d;
      frame_q <= frame_d;
      height_q <= height_d;
      done_q <= done_d;
    end
  end

  // Outputs straight from flip-flops; busy is decoded from the state register
  assign o_wr_valid = valid_q;
  assign o_wr_addr = addr_q;
  assign o_wr_data = data_q;
  assign o_wr_cacheable = cache_q;
  assign o_tail_ptr = tail_q;
  assign o_tail_frame = frame_q;
  assign o_busy = (state_q != ST_IDLE);
  assign o_frame_done = done_q;

  // Caching off means no cacheable write ever leaves
  AST_UNCACHED_WHEN_OFF: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R1]
    take && !i_cache_enable |=> o_wr_valid && !o_wr_cacheable)
    else $error("cacheable write issued while caching disabled");

  // Encoder passing the writer on the same frame gives a cacheable write
  AST_PASSING_CACHED: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R4]
    take && i_cache_enable && (i_head_frame == o_tail_frame) && !(i_head_ptr < o_tail_ptr)
    |=> o_wr_cacheable)
    else $error("passing encoder did not give cacheable write");

  // Same frame, head behind tail: attribute follows the distance test
  AST_SAME_FRAME_DIST: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R3]
    take && i_cache_enable && (i_head_frame == o_tail_frame) && (i_head_ptr < o_tail_ptr)
    |=> o_wr_cacheable == ($past(o_tail_ptr) - $past(i_head_ptr) <= $past(i_cache_max_diff)))
    else $error("same frame distance test wrong");

  // Capture start loads the tail with the programmed offset
  AST_TAIL_OFFSET: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R9]
    (state_q == ST_IDLE) && i_capture_start |=> o_tail_ptr == $past(i_tail_offset))
    else $error("tail pointer not loaded with offset");

  // Held write stays stable until accepted
  AST_WRITE_HOLD: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R16]
    o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr_addr) && $stable(o_wr_data))
    else $error("write changed before acceptance");

  // A new capture writes its first pixel to the surface base
  AST_FIRST_ADDR: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R16]
    (state_q == ST_IDLE) && i_capture_start ##1 take && x_q == '0 && y_q == '0
    |=> o_wr_addr == $past(i_surface_base, 2))
    else $error("first write not at surface base");

  // Different frames, encoder done with previous: tail alone decides
  AST_DIFF_FRAME_DONE: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R5]
    take && i_cache_enable && (i_head_frame != o_tail_frame) && (i_head_ptr > frame_ptr)
    |=> o_wr_cacheable == ($past(o_tail_ptr) <= $past(i_cache_max_diff)))
    else $error("different frame test with finished encoder wrong");

  // Different frames, encoder still on the previous one: wrapped distance decides
  AST_DIFF_FRAME_PREV: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R6]
    take && i_cache_enable && (i_head_frame != o_tail_frame) && !(i_head_ptr > frame_ptr)
    |=> o_wr_cacheable == ({1'b0, $past(frame_ptr)} - {1'b0, $past(i_head_ptr)}
                           + {1'b0, $past(o_tail_ptr)} <= {1'b0, $past(i_cache_max_diff)}))
    else $error("different frame test with busy encoder wrong");

  // Completion pulse comes only after the last write drained
  AST_DONE_DRAINED: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R17]
    o_frame_done |-> !o_wr_valid && !o_busy)
    else $error("frame done while write pending");

endmodule

// File: tb/capture_writer_tb.sv
/*
  Self-checking bench for the capture writer: table of cache cases, then reset cases.
  Assumes the design package is compiled first and the memory model sits on the write port.
*/
`timescale 1ns/100ps

module capture_writer_tb
  import capture_write_pkg::*;
;
  typedef struct packed
  {
    logic        en;
    logic [7:0]  maxd;
    logic [7:0]  off;
    logic [7:0]  head;
    logic        same;
    logic [11:0] vact;
    logic        slow;
    logic        exp;
  } row_type;

  logic I_CORE_CLK = 1'b0, I_RST = 1'b1, i_capture_start = 1'b0, i_cache_enable = 1'b0;
  logic i_frame_vactive_set = 1'b0, i_pix_valid = 1'b0, clear = 1'b0, slow = 1'b0;
  logic [7:0] i_frame_number = 8'h00, i_head_frame = 8'h00;
  ptr_type i_cache_max_diff = 8'h00, i_tail_offset = 8'h00, i_head_ptr = 8'h00;
  logic [31:0] i_surface_base = 32'h0, i_pix_data = 32'h0, last_addr, last_data;
  logic [11:0] i_vactive = 12'h001, i_frame_vactive = 12'h000;
  logic o_pix_ready, o_wr_valid, i_wr_ready, o_wr_cacheable, o_busy, o_frame_done, first_cache;
  logic [31:0] o_wr_addr, o_wr_data;
  ptr_type o_tail_ptr;
  logic [7:0] o_tail_frame, count;
  int fails = 0, samples_checked = 0, cycles = 0;
  row_type rows [9];

  capture_writer i_dut (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST),
    .i_capture_start(i_capture_start), .i_frame_number(i_frame_number),
    .i_cache_enable(i_cache_enable), .i_cache_max_diff(i_cache_max_diff),
    .i_tail_offset(i_tail_offset), .i_surface_base(i_surface_base),
    .i_surface_pitch(32'h0000_0100), .i_hactive(13'h0002), .i_vactive(i_vactive),
    .i_frame_vactive_set(i_frame_vactive_set), .i_frame_vactive(i_frame_vactive),
    .i_pix_valid(i_pix_valid), .i_pix_data(i_pix_data), .o_pix_ready(o_pix_ready),
    .i_head_ptr(i_head_ptr), .i_head_frame(i_head_frame), .o_wr_valid(o_wr_valid),
    .i_wr_ready(i_wr_ready), .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data),
    .o_wr_cacheable(o_wr_cacheable), .o_tail_ptr(o_tail_ptr), .o_tail_frame(o_tail_frame),
    .o_busy(o_busy), .o_frame_done(o_frame_done));

  memory_sink_model i_mem (.i_clk(I_CORE_CLK), .i_rst(I_RST), .i_clear(clear),
    .i_slow(slow), .i_wr_valid(o_wr_valid), .i_wr_addr(o_wr_addr), .i_wr_data(o_wr_data),
    .i_wr_cacheable(o_wr_cacheable), .o_wr_ready(i_wr_ready), .o_count(count),
    .o_first_cache(first_cache), .o_last_addr(last_addr), .o_last_data(last_data));

  always #4 I_CORE_CLK = ~I_CORE_CLK;

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard well beyond the longest expected run
  always @(posedge I_CORE_CLK)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fails++;
      conclude();
    end
  end

  // Idle outputs while reset holds and just after it
  task automatic check_idle();
    check("busy", o_busy, 0);
    check("wr_valid", o_wr_valid, 0);
    check("pix_ready", o_pix_ready, 0);
    check("frame_done", o_frame_done, 0);
    check("tail_ptr", o_tail_ptr, 0);
    check("tail_frame", o_tail_frame, 0);
    check("cacheable", o_wr_cacheable, 0);
  endtask

  // One capture: two pixels a line, pixels offered back to back in raster order
  task automatic run_row(row_type r, int k);
    logic took;
    logic done;
    int n;
    int total;
    logic [31:0] base;
    total = 2 * r.vact;
    base = 32'h1000_0000 + ({24'h0, r.off} << 12);
    @(negedge I_CORE_CLK);
    clear = 1'b1;
    slow = r.slow;
    i_cache_enable = r.en;
    i_cache_max_diff = r.maxd;
    i_tail_offset = r.off;
    i_surface_base = base;
    i_vactive = r.vact;
    i_head_ptr = r.head;
    i_frame_number = k + 1;
    i_head_frame = r.same ? k + 1 : k;
    i_capture_start = 1'b1;
    i_pix_valid = 1'b1;
    i_pix_data = 32'h1;
    @(negedge I_CORE_CLK);
    clear = 1'b0;
    i_capture_start = 1'b0;
    n = 0;
    done = 1'b0;
    took = (o_pix_ready === 1'b1) && i_pix_valid;
    for (int c = 0; c < 400 && !done; c++)
    begin
      @(negedge I_CORE_CLK);
      done = (o_frame_done === 1'b1);
      if (took)
      begin
        n++;
        i_pix_data = n + 1;
        i_pix_valid = (n < total);
      end
      took = (o_pix_ready === 1'b1) && i_pix_valid;
    end
    check("frame_done", done, 1);
    check("cacheable", first_cache, r.exp);
    check("writes", count, total);
    check("last_addr", last_addr, base + (r.vact - 1) * 32'h100 + 32'h4);
    check("last_data", last_data, total);
    check("tail_ptr", o_tail_ptr, r.off + (r.vact > 16 ? 2 : 1));
    check("tail_frame", o_tail_frame, k + 1);
    check("busy", o_busy, 0);
  endtask

  initial
  begin
    // en maxd off head same vact slow expected; first row is a 17-line capture from frame start
    rows = '{'{1, 8'h00, 8'h00, 8'h00, 1, 12'h011, 1, 1}, '{0, 8'hFF, 8'h00, 8'h00, 1, 12'h1, 0, 0},
             '{1, 8'h03, 8'h05, 8'h02, 1, 12'h1, 0, 1}, '{1, 8'h03, 8'h05, 8'h01, 1, 12'h1, 1, 0},
             '{1, 8'h00, 8'h05, 8'h07, 1, 12'h1, 0, 1}, '{1, 8'h02, 8'h02, 8'h05, 0, 12'h1, 0, 1},
             '{1, 8'h02, 8'h03, 8'h05, 0, 12'h1, 0, 0}, '{1, 8'h02, 8'h01, 8'h03, 0, 12'h1, 0, 1},
             '{1, 8'h02, 8'h01, 8'h02, 0, 12'h1, 0, 0}};
    repeat (10) @(negedge I_CORE_CLK);
    check_idle();
    I_RST = 1'b0;
    @(negedge I_CORE_CLK);
    check_idle();
    // Full frame height of 64 lines is four pointer units
    i_frame_vactive = 12'h040;
    i_frame_vactive_set = 1'b1;
    @(negedge I_CORE_CLK);
    i_frame_vactive_set = 1'b0;
    foreach (rows[k])
      run_row(rows[k], k);
    // Reset in mid-capture, then a clean capture right after; 17 lines keep it busy
    @(negedge I_CORE_CLK);
    i_vactive = 12'h011;
    i_capture_start = 1'b1;
    i_pix_valid = 1'b1;
    @(negedge I_CORE_CLK);
    i_capture_start = 1'b0;
    repeat (4) @(negedge I_CORE_CLK);
    check("busy_mid", o_busy, 1);
    I_RST = 1'b1;
    i_pix_valid = 1'b0;
    @(negedge I_CORE_CLK);
    check_idle();
    I_RST = 1'b0;
    @(negedge I_CORE_CLK);
    check_idle();
    run_row(rows[2], 2);
    conclude();
  end
endmodule

// File: tb/memory_sink_model.sv
/*
  Memory side of the capture writer: accepts writes, stalls on request, keeps a tally.
  Assumes the bench clears the tally before each capture.
*/
`timescale 1ns/100ps

module memory_sink_model
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_clear,
  input  wire logic        i_slow,
  input  wire logic        i_wr_valid,
  input  wire logic [31:0] i_wr_addr,
  input  wire logic [31:0] i_wr_data,
  input  wire logic        i_wr_cacheable,
  output logic             o_wr_ready,
  output logic [7:0]       o_count,
  output logic             o_first_cache,
  output logic [31:0]      o_last_addr,
  output logic [31:0]      o_last_data
);
  logic [1:0] phase;

  // Ready moves only after an edge; slow mode raises ready one cycle in four to stall the writer
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      phase <= 2'h0;
      o_wr_ready <= 1'b0;
      o_count <= 8'h00;
    end
    else
    begin
      phase <= phase + 2'h1;
      o_wr_ready <= !i_slow || (phase == 2'h2);
      if (i_clear)
        o_count <= 8'h00;
      // Reader consumes any part of the buffer; only the tally matters here
      else if (i_wr_valid && o_wr_ready)
      begin
        if (o_count == 8'h00)
          o_first_cache <= i_wr_cacheable;
        o_count <= o_count + 8'h01;
        o_last_addr <= i_wr_addr;
        o_last_data <= i_wr_data;
      end
    end
  end
endmodule
